// file: core/lam_consts.svh
// Named offsets, field positions, reset values and timing for the output macrocells.
// Assumes inclusion by bare name from lam_pkg and the macrocell top module.
`ifndef LAM_CONSTS_SVH
`define LAM_CONSTS_SVH

`define LAM_CELLS 8
`define LAM_TERMS 8
`define LAM_OFF_CFG 5'h00
`define LAM_OFF_CTRL 5'h04
`define LAM_OFF_STATUS 5'h08
`define LAM_OFF_SIG_LO 5'h0c
`define LAM_OFF_SIG_HI 5'h10
`define LAM_CFG_SEL_A 0
`define LAM_CFG_SEL_B 1
`define LAM_CFG_MODE_LSB 8
`define LAM_CFG_POL_LSB 16
`define LAM_CTRL_LOCK 0
`define LAM_CTRL_PRELOAD 1
`define LAM_CTRL_SECURE 2
`define LAM_CTRL_ERASE 3
`define LAM_ST_STANDBY 0
`define LAM_ST_SECURED 1
`define LAM_ST_INVALID 2
`define LAM_ST_LOCKED 3
`define LAM_ST_Q_LSB 8
`define LAM_ST_OUT_LSB 16
`define LAM_ST_OE_LSB 24
`define LAM_CFG_RESET 8'h00
`define LAM_SIG_RESET 64'h0000_0000_0000_0000
`define LAM_PIN_RESET 8'hff
`define LAM_RESP_OKAY 2'b00
`define LAM_RESP_SLVERR 2'b10
`define LAM_STANDBY_NS 50
`define LAM_CLK_NS 20
`define LAM_STANDBY_CYC ((`LAM_STANDBY_NS + `LAM_CLK_NS - 1) / `LAM_CLK_NS)

`endif

// file: core/lam_pkg.sv
// Types shared by the macrocell top: cell configuration codes and the state record.
// Assumes lam_consts.svh is on the include path.
`include "lam_consts.svh"

package lam_pkg;

  // Code is {global_arch_sel_a, global_arch_sel_b, cell_mode_bit}
  typedef enum logic [2:0] {
    lam_cfg_reg_out = 3'b010,
    lam_cfg_comb_io_reg = 3'b011,
    lam_cfg_comb_out = 3'b100,
    lam_cfg_input = 3'b101,
    lam_cfg_comb_io = 3'b111
  } lam_cell_cfg_e;

  typedef struct packed {
    logic aw_got;
    logic aw_hit;
    logic [4:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic sel_a;
    logic sel_b;
    logic [`LAM_CELLS-1:0] mode;
    logic [`LAM_CELLS-1:0] pol;
    logic locked;
    logic secured;
    logic [63:0] sig;
    logic preload_pend;
    logic [`LAM_CELLS-1:0] q;
    logic [`LAM_CELLS-1:0] pin_out;
    logic [`LAM_CELLS-1:0] pin_oe_n;
    logic [`LAM_CELLS-1:0] fb;
    logic [2:0] idle_cnt;
    logic standby;
    logic [`LAM_CELLS+1:0] prev_pins;
    logic [`LAM_CELLS*`LAM_TERMS-1:0] prev_pterm;
  } lam_state_s;

endpackage : lam_pkg

// file: core/lam_sync.sv
// Two-stage synchroniser for pin levels entering the ref_clk domain.
// Assumes inputs are asynchronous levels; only the second stage may be read.
`timescale 1ns/1ns

module lam_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lam_sync_s;

  lam_sync_s st;
  lam_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;

endmodule : lam_sync

// file: core/lam_macrocells.sv
// Eight configurable output macrocells with an AXI4-Lite register slave.
// Assumes product terms come from same-clock array logic; pins are asynchronous.
// What this block does
// - Non-registered comb I/O: seven terms to OR, eighth enables buffer.
// - Non-registered comb I/O: pin level feeds back to the array.
// - No registers: clock and enable pins feed back via last and first cells.
// - Registered-device comb I/O: seven terms, eighth enables, own pin feeds back.
// - Dedicated input: output buffer always disabled.
// - Dedicated input feedback from adjacent pin; end cells use enable/clock pins.
// - Polarity bit XORs the sum: 1 active high, 0 active low.
// - Combinatorial output: centre cells give no feedback.
// - Centre cells cannot be dedicated inputs; such a setting is invalid.
// - Inputs idle about 50 ns puts the block into standby.
// - Standby holds outputs; any input change resumes with no added delay.
// - Flip-flops clear low at start; registered outputs then read high.
// - Registers can be preloaded with arbitrary states from the output pins.
// - Preload works whether or not the security bit is set.
// - Security set refuses configuration readback, programming and verification.
// - Security bit clears only with a full array erase or with rst.
// - 64-bit signature word stays readable regardless of security.
// - Registered output: eight terms, clocked on rising edge, Q-bar feedback, pin enable.
// - Combinatorial output: eight terms, feedback on except in centre cells.
// - End cells steer feedback mux with inverted sel_a instead of sel_b.
// - Configuration: two global bits, one mode and one polarity bit per cell.
`timescale 1ns/1ns
`include "lam_consts.svh"

module lam_macrocells
  import lam_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clk_pin,
  input wire logic shared_drive_enable_n,
  input wire logic [`LAM_CELLS-1:0] io_in,
  output logic [`LAM_CELLS-1:0] io_out,
  output logic [`LAM_CELLS-1:0] io_oe_n,
  input wire logic [`LAM_CELLS*`LAM_TERMS-1:0] product_term,
  output logic [`LAM_CELLS-1:0] array_feedback
);

  localparam int NC = `LAM_CELLS;
  localparam int NT = `LAM_TERMS;
  localparam logic [2:0] IDLE_CYC = 3'(`LAM_STANDBY_CYC);
  localparam int CENTRE_LO = NC / 2 - 1;
  localparam int CENTRE_HI = NC / 2;

  lam_state_s st;
  lam_state_s next_st;

  logic [NC-1:0] io_s;
  logic [1:0] ctl_s;
  logic clk_s;
  logic oe_pin_n_s;
  logic [NC-1:0] cell_x;
  logic [NC-1:0] cell_oe_n;
  logic [NC-1:0] cell_fb;
  logic [NC-1:0] cell_is_reg;
  logic [NC-1:0] cell_bad;
  logic [NC-1:0] next_q;
  logic clk_rise;

  lam_sync #(.W(NC)) u_sync_io (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(io_in),
    .sync_out(io_s)
  );

  lam_sync #(.W(2)) u_sync_ctl (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({clk_pin, shared_drive_enable_n}),
    .sync_out(ctl_s)
  );

  assign clk_s = ctl_s[1];
  assign oe_pin_n_s = ctl_s[0];
  assign clk_rise = clk_s & ~st.prev_pins[NC+1];

  function automatic logic [31:0] lam_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : lam_merge

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_cell
      lam_cell_cfg_e cfg;
      logic sum7;
      logic pt_last;
      logic sum;
      logic adj;
      logic fb_hi_sel;
      logic centre;

      assign cfg = lam_cell_cfg_e'({st.sel_a, st.sel_b, st.mode[gi]});
      assign sum7 = |product_term[gi*NT +: NT-1];
      assign pt_last = product_term[gi*NT + NT - 1];
      assign centre = (gi == CENTRE_LO) || (gi == CENTRE_HI);
      // Comb I/O reserves the last term for the enable and dedicated input drops it; other modes OR all eight
      assign sum = st.mode[gi] ? sum7 : (sum7 | pt_last);
      assign cell_x[gi] = st.pol[gi] ? sum : ~sum;
      assign cell_is_reg[gi] = (cfg == lam_cfg_reg_out);

      if (gi == 0) begin : g_adj_first
        assign adj = ~oe_pin_n_s;
      end else if (gi == NC - 1) begin : g_adj_last
        assign adj = clk_s;
      end else if (gi < NC / 2) begin : g_adj_low
        assign adj = io_s[gi-1];
      end else begin : g_adj_high
        assign adj = io_s[gi+1];
      end

      if (gi == 0 || gi == NC - 1) begin : g_sel_end
        assign fb_hi_sel = ~st.sel_a;
      end else begin : g_sel_mid
        assign fb_hi_sel = st.sel_b;
      end

      always_comb begin
        cell_oe_n[gi] = 1'b1;
        cell_fb[gi] = 1'b0;
        cell_bad[gi] = 1'b0;
        case (cfg)
          lam_cfg_reg_out: begin
            cell_oe_n[gi] = oe_pin_n_s;
            cell_fb[gi] = ~next_q[gi];
          end
          lam_cfg_comb_io_reg, lam_cfg_comb_io: begin
            cell_oe_n[gi] = ~pt_last;
            cell_fb[gi] = fb_hi_sel ? io_s[gi] : adj;
          end
          lam_cfg_comb_out: begin
            cell_oe_n[gi] = 1'b0;
            cell_fb[gi] = centre ? 1'b0 : adj;
          end
          lam_cfg_input: begin
            cell_oe_n[gi] = 1'b1;
            cell_fb[gi] = centre ? 1'b0 : adj;
            cell_bad[gi] = centre;
          end
          default: begin
            // Unprogrammed or undefined code: pin stays off the wire
            cell_bad[gi] = 1'b1;
          end
        endcase
      end

      // Flip-flop holds the inverse so a cleared register drives the pin high
      always_comb begin
        next_q[gi] = st.q[gi];
        if (st.preload_pend) begin
          next_q[gi] = ~io_s[gi];
        end else if (cell_is_reg[gi] && clk_rise && !st.sel_a) begin
          next_q[gi] = ~cell_x[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    logic changed;
    logic awake;
    logic wr_fire;
    logic wr_ok;
    logic [31:0] merged;
    logic [31:0] cfg_word;
    logic [4:0] ra;
    logic ra_hit;
    changed = 1'b0;
    awake = 1'b0;
    wr_fire = 1'b0;
    wr_ok = 1'b1;
    merged = '0;
    cfg_word = '0;
    ra = '0;
    ra_hit = 1'b0;
    next_st = st;

    // Standby: a change of any input wakes immediately, so no cycle is added
    changed = ({clk_s, oe_pin_n_s, io_s} != st.prev_pins) || (product_term != st.prev_pterm);
    awake = changed || (st.idle_cnt < IDLE_CYC);
    next_st.prev_pins = {clk_s, oe_pin_n_s, io_s};
    next_st.prev_pterm = product_term;
    if (changed) begin
      next_st.idle_cnt = '0;
    end else if (st.idle_cnt < IDLE_CYC) begin
      next_st.idle_cnt = st.idle_cnt + 3'd1;
    end
    next_st.standby = ~awake;

    next_st.q = next_q;
    next_st.preload_pend = 1'b0;
    // Preload is a test action, so it refreshes the pins even in standby
    if (awake || st.preload_pend) begin
      for (int i = 0; i < NC; i++) begin
        next_st.pin_out[i] = cell_is_reg[i] ? ~next_q[i] : cell_x[i];
      end
      next_st.pin_oe_n = cell_oe_n;
      next_st.fb = cell_fb;
    end

    cfg_word = '0;
    cfg_word[`LAM_CFG_SEL_A] = st.sel_a;
    cfg_word[`LAM_CFG_SEL_B] = st.sel_b;
    cfg_word[`LAM_CFG_MODE_LSB +: NC] = st.mode;
    cfg_word[`LAM_CFG_POL_LSB +: NC] = st.pol;

    // Write channel: address and data taken in either order, answered after both
    if (s_axi_awvalid && !st.aw_got && !st.bvalid) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr[4:0];
      next_st.aw_hit = (s_axi_awaddr[ADDR_W-1:5] == '0) && (s_axi_awaddr[1:0] == 2'b00);
    end
    if (s_axi_wvalid && !st.w_got && !st.bvalid) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    wr_fire = st.aw_got && st.w_got && !st.bvalid;
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      wr_ok = st.aw_hit;
      if (st.aw_hit) begin
        case (st.aw_addr)
          `LAM_OFF_CFG: begin
            // Programming is refused while locked for operation or secured
            if (st.locked || st.secured) begin
              wr_ok = 1'b0;
            end else begin
              merged = lam_merge(cfg_word, st.w_data, st.w_strb);
              next_st.sel_a = merged[`LAM_CFG_SEL_A];
              next_st.sel_b = merged[`LAM_CFG_SEL_B];
              next_st.mode = merged[`LAM_CFG_MODE_LSB +: NC];
              next_st.pol = merged[`LAM_CFG_POL_LSB +: NC];
            end
          end
          `LAM_OFF_CTRL: begin
            // A refused erase must not drop the lock either
            if (st.w_strb[0] && st.w_data[`LAM_CTRL_ERASE] && st.locked) begin
              wr_ok = 1'b0;
            end else if (st.w_strb[0]) begin
              next_st.locked = st.w_data[`LAM_CTRL_LOCK];
              if (st.w_data[`LAM_CTRL_PRELOAD]) begin
                next_st.preload_pend = 1'b1;
              end
              if (st.w_data[`LAM_CTRL_SECURE]) begin
                next_st.secured = 1'b1;
              end
              if (st.w_data[`LAM_CTRL_ERASE]) begin
                // Erase returns the whole array to the blank state at once
                next_st.secured = 1'b0;
                next_st.locked = 1'b0;
                next_st.sel_a = 1'b0;
                next_st.sel_b = 1'b0;
                next_st.mode = `LAM_CFG_RESET;
                next_st.pol = `LAM_CFG_RESET;
                next_st.sig = `LAM_SIG_RESET;
              end
            end
          end
          `LAM_OFF_SIG_LO: begin
            if (st.locked || st.secured) begin
              wr_ok = 1'b0;
            end else begin
              next_st.sig[31:0] = lam_merge(st.sig[31:0], st.w_data, st.w_strb);
            end
          end
          `LAM_OFF_SIG_HI: begin
            if (st.locked || st.secured) begin
              wr_ok = 1'b0;
            end else begin
              next_st.sig[63:32] = lam_merge(st.sig[63:32], st.w_data, st.w_strb);
            end
          end
          default: begin
            wr_ok = 1'b0;
          end
        endcase
      end
      next_st.bresp = wr_ok ? `LAM_RESP_OKAY : `LAM_RESP_SLVERR;
    end

    // Read channel: one outstanding read, data registered with the answer
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid) begin
      ra = s_axi_araddr[4:0];
      ra_hit = (s_axi_araddr[ADDR_W-1:5] == '0) && (s_axi_araddr[1:0] == 2'b00);
      next_st.rvalid = 1'b1;
      next_st.rdata = '0;
      next_st.rresp = `LAM_RESP_OKAY;
      if (!ra_hit) begin
        next_st.rresp = `LAM_RESP_SLVERR;
      end else begin
        case (ra)
          `LAM_OFF_CFG: begin
            if (st.secured) begin
              next_st.rresp = `LAM_RESP_SLVERR;
            end else begin
              next_st.rdata = cfg_word;
            end
          end
          `LAM_OFF_CTRL: begin
            next_st.rdata[`LAM_CTRL_LOCK] = st.locked;
          end
          `LAM_OFF_STATUS: begin
            next_st.rdata[`LAM_ST_STANDBY] = st.standby;
            next_st.rdata[`LAM_ST_SECURED] = st.secured;
            next_st.rdata[`LAM_ST_INVALID] = |cell_bad;
            next_st.rdata[`LAM_ST_LOCKED] = st.locked;
            next_st.rdata[`LAM_ST_Q_LSB +: NC] = st.q;
            next_st.rdata[`LAM_ST_OUT_LSB +: NC] = st.pin_out;
            next_st.rdata[`LAM_ST_OE_LSB +: NC] = st.pin_oe_n;
          end
          `LAM_OFF_SIG_LO: begin
            next_st.rdata = st.sig[31:0];
          end
          `LAM_OFF_SIG_HI: begin
            next_st.rdata = st.sig[63:32];
          end
          default: begin
            next_st.rresp = `LAM_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.pin_out <= `LAM_PIN_RESET;
      st.pin_oe_n <= `LAM_PIN_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready = !st.w_got && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign io_out = st.pin_out;
  assign io_oe_n = st.pin_oe_n;
  assign array_feedback = st.fb;

endmodule : lam_macrocells

// file: dv/lam_chk.sv
// Concurrent checks on the macrocell top: AXI handshakes and pin reset state.
// Assumes the bench keeps one write and one read in flight at a time.
`timescale 1ns/1ns
`include "lam_consts.svh"
module lam_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`LAM_CELLS-1:0] io_out,
  input wire logic [`LAM_CELLS-1:0] io_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not cleared");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not cleared");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {`LAM_RESP_OKAY,
    `LAM_RESP_SLVERR}) else $error("bad write response code");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `LAM_RESP_SLVERR |->
    s_axi_rdata == 32'h0) else $error("refused read leaks data");
  reset_pins_a: assert property (disable iff (1'b0) rst |=> !s_axi_bvalid &&
    !s_axi_rvalid && io_oe_n == `LAM_PIN_RESET && io_out == `LAM_PIN_RESET)
    else $error("reset state wrong");
endmodule : lam_chk

bind lam_macrocells lam_chk lam_chk_i (.ref_clk(ref_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .io_out(io_out), .io_oe_n(io_oe_n));

// file: dv/lam_board.sv
// Board model: resolves each I/O pin from the cell's drive and the board's own level.
// Assumes a released pin is held by board logic at ext, never floating.
`timescale 1ns/1ns
`include "lam_consts.svh"
module lam_board (
  input wire logic [`LAM_CELLS-1:0] io_out,
  input wire logic [`LAM_CELLS-1:0] io_oe_n,
  input wire logic [`LAM_CELLS-1:0] ext,
  output logic [`LAM_CELLS-1:0] io_in
);
  // A driven pin reads back the cell value, a released one the board level
  assign io_in = (io_out & ~io_oe_n) | (ext & io_oe_n);
endmodule : lam_board

// file: dv/tb.sv
// Self-checking bench for the macrocell top: random cell setups plus corner cases.
// Assumes lam_consts.svh on the include path and the board model beside the design.
`timescale 1ns/1ns
`include "lam_consts.svh"
module tb;
  localparam logic [11:0] A_CFG = 12'h000, A_CTL = 12'h004, A_ST = 12'h008;
  localparam logic [11:0] A_SL = 12'h00c, A_SH = 12'h010;
  localparam logic [1:0] OK = `LAM_RESP_OKAY, ERR = `LAM_RESP_SLVERR;
  logic ref_clk = 1'b0, rst = 1'b1, clk_pin = 1'b0, sen_n = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] ext = '0, io_in, io_out, io_oe_n, fb;
  logic [63:0] pt = '0;
  int n_fail = 0, n_tests = 0, seed = 11726;

  always #10 ref_clk = ~ref_clk;

  lam_macrocells lam_macrocells_i (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clk_pin(clk_pin),
    .shared_drive_enable_n(sen_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .product_term(pt), .array_feedback(fb));
  lam_board lam_board_i (.io_out(io_out), .io_oe_n(io_oe_n), .ext(ext), .io_in(io_in));

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic hung();
    n_fail++;
    $display("wrong value at %0t: wait ran out", $time);
    wrap_up();
  endtask : hung

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    chk_val({30'h0, g}, {30'h0, e});
  endtask : chk_resp

  // Both channels offered together, each released at its own take
  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 64) hung();
    chk_resp(bresp, er);
  endtask : wr_chk

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 64) hung();
    chk_val(rdata & m, e);
    chk_resp(rresp, er);
  endtask : rd_chk

  function automatic logic [7:0] f_out(input logic [2:0] c, input logic [63:0] t,
                                       input logic [7:0] p);
    logic [7:0] x;
    for (int i = 0; i < 8; i++) x[i] = ~p[i] ^ (|t[8*i +: 7] | (t[8*i+7] & ~c[0]));
    return x;
  endfunction : f_out

  function automatic logic [7:0] f_oe(input logic [2:0] c, input logic [63:0] t,
                                      input logic s);
    logic [7:0] o;
    for (int i = 0; i < 8; i++) o[i] = ~t[8*i+7];
    if (c == 3'b010) o = {8{s}};
    if (c == 3'b100) o = 8'h00;
    if (c == 3'b101) o = 8'hff;
    return o;
  endfunction : f_oe

  function automatic logic [7:0] f_fb(input logic [2:0] c, input logic [7:0] x,
                                      input logic [7:0] pin, input logic s, input logic ck);
    logic [7:0] a;
    a = {ck, pin[7:5], pin[2:0], ~s};
    if (c == 3'b100 || c == 3'b101) return a & 8'he7;
    if (c == 3'b111) return {ck, pin[6:1], ~s};
    if (c == 3'b010) return x;
    return pin;
  endfunction : f_fb

  initial begin
    repeat (20000) @(posedge ref_clk);
    hung();
  end

  initial begin
    logic [2:0] cs [4];
    logic [2:0] c;
    logic [7:0] p, x, o, pin;
    logic [63:0] sg;
    cs = '{3'b100, 3'b101, 3'b111, 3'b011};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd_chk(A_ST, 32'hffff_fffe, 32'hffff_0004, OK);
    rd_chk(A_CFG, 32'hffff_ffff, 32'h0, OK);
    rd_chk(12'h014, 32'hffff_ffff, 32'h0, ERR);
    wr_chk(12'h014, 32'h1, ERR);
    wr_chk(A_ST, 32'h0, ERR);
    sg = {$random(seed), $random(seed)};
    wr_chk(A_SL, sg[31:0], OK);
    wr_chk(A_SH, sg[63:32], OK);
    for (int k = 0; k < 8; k++) begin
      c = cs[k % 4];
      p = 8'($random(seed));
      wr_chk(A_CFG, {8'h00, p, {8{c[0]}}, 6'h00, c[1], c[2]}, OK);
      pt <= {$random(seed), $random(seed)};
      ext <= 8'($random(seed));
      sen_n <= 1'($random(seed));
      clk_pin <= c[2] & 1'($random(seed));
      repeat (8) @(posedge ref_clk);
      x = f_out(c, pt, p);
      o = f_oe(c, pt, sen_n);
      pin = (ext & o) | (x & ~o);
      chk_val({24'h0, io_out & ~o}, {24'h0, x & ~o});
      chk_val({24'h0, io_oe_n}, {24'h0, o});
      chk_val({24'h0, fb},
        {24'h0, f_fb(c, x, pin, sen_n, clk_pin)});
      rd_chk(A_ST, 32'h5, {29'h0, c == 3'b101, 2'b01}, OK);
    end
    c = 3'b010;
    p = 8'($random(seed));
    wr_chk(A_CFG, {8'h00, p, 16'h0002}, OK);
    clk_pin <= 1'b0;
    sen_n <= 1'b0;
    pt <= {$random(seed), $random(seed)};
    repeat (8) @(posedge ref_clk);
    chk_val({24'h0, io_out}, 32'hff);
    chk_val({24'h0, io_oe_n}, 32'h0);
    clk_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    x = f_out(c, pt, p);
    chk_val({24'h0, io_out}, {24'h0, x});
    chk_val({24'h0, fb}, {24'h0, f_fb(c, x, 8'h0, 1'b0, 1'b0)});
    wr_chk(A_CTL, 32'h4, OK);
    rd_chk(A_CFG, 32'hffff_ffff, 32'h0, ERR);
    wr_chk(A_CFG, 32'h0, ERR);
    rd_chk(A_SL, 32'hffff_ffff, sg[31:0], OK);
    rd_chk(A_SH, 32'hffff_ffff, sg[63:32], OK);
    // Released pins let the board level reach the preload path
    sen_n <= 1'b1;
    ext <= 8'($random(seed));
    repeat (8) @(posedge ref_clk);
    wr_chk(A_CTL, 32'h2, OK);
    repeat (8) @(posedge ref_clk);
    chk_val({24'h0, io_out}, {24'h0, ext});
    rd_chk(A_ST, 32'hff02, {16'h0, ~ext, 8'h02}, OK);
    wr_chk(A_CTL, 32'h8, OK);
    rd_chk(A_CFG, 32'hffff_ffff, 32'h0, OK);
    rd_chk(A_ST, 32'h2, 32'h0, OK);
    wr_chk(A_CTL, 32'h1, OK);
    rd_chk(A_CTL, 32'h1, 32'h1, OK);
    wr_chk(A_CFG, 32'h0, ERR);
    wr_chk(A_CTL, 32'h8, ERR);
    rd_chk(A_CTL, 32'h1, 32'h1, OK);
    wr_chk(A_CTL, 32'h0, OK);
    wrap_up();
  end
endmodule : tb
